// ==== src/adcr_params.svh ====
// Register offsets, field positions and reset values of the result block
`ifndef ADCR_PARAMS_SVH
`define ADCR_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADCR_OFS_SLOT7      8'h00
`define ADCR_OFS_PRIO       8'h04
`define ADCR_OFS_CMP0       8'h08
`define ADCR_OFS_MONCTL     8'h0C
`define ADCR_OFS_IRQSTAT    8'h10
`define ADCR_OFS_IRQMASK    8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCR_RES_MSB        15
`define ADCR_RES_LSB        6
`define ADCR_OVR_BIT        1
`define ADCR_RF_BIT         0
`define ADCR_MON_EN_BIT     0
`define ADCR_MON_DIR_BIT    1
`define ADCR_MON_SEL_BIT    2
`define ADCR_IRQ_HIT_BIT    0
`define ADCR_IRQ_SLOT7_OVERRUN_BIT   1
`define ADCR_IRQ_PRIORITY_OVERRUN_BIT  2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADCR_RST_VALUE      10'h000
`define ADCR_RST_IRQ        3'h0
`define ADCR_RST_WORD       32'h00000000

`endif

// ==== src/adcr_pkg.sv ====
// Types shared by the result block modules
package adcr_pkg;

  // Result register chosen by the monitor
  typedef enum logic [0:0] {
    ADCR_SEL_SLOT7 = 1'b0,
    ADCR_SEL_PRIO  = 1'b1
  } adcr_sel_t;

  // Compare direction of the monitor
  typedef enum logic [0:0] {
    ADCR_DIR_SMALLER = 1'b0,
    ADCR_DIR_LARGER  = 1'b1
  } adcr_dir_t;

  // Register addressed by a bus transfer
  typedef enum logic [2:0] {
    ADCR_REG_SLOT7   = 3'h0,
    ADCR_REG_PRIO    = 3'h1,
    ADCR_REG_CMP0    = 3'h2,
    ADCR_REG_MONCTL  = 3'h3,
    ADCR_REG_IRQSTAT = 3'h4,
    ADCR_REG_IRQMASK = 3'h5,
    ADCR_REG_NONE    = 3'h6
  } adcr_reg_t;

  // Result store strobe with its data
  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } adcr_store_t;

  // Content of one result register
  typedef struct packed {
    logic [9:0] value;
    logic       overrun;
    logic       stored;
  } adcr_result_t;

  // Monitor 0 control settings
  typedef struct packed {
    adcr_sel_t select;
    adcr_dir_t direction;
    logic      enable;
  } adcr_mon_ctrl_t;

endpackage : adcr_pkg

// ==== src/adcr_result_slot.sv ====
// One conversion result register with its overrun and stored flags
`timescale 1ns/100ps
`default_nettype none

`include "adcr_params.svh"

module adcr_result_slot
  import adcr_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Converter side
  input  wire adcr_store_t  store,
  // Bus side
  input  wire logic         read_clear,
  output var  adcr_result_t result
);

  logic [9:0] value;
  logic       overrun;
  logic       stored;

  // ----------------------------------------------------------------
  // Result value
  // ----------------------------------------------------------------
  // Every store replaces the held result
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value <= `ADCR_RST_VALUE;
    end else if (store.valid) begin
      value <= store.data;
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Stored flag: a store in the read cycle wins over the clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stored <= 1'b0;
    end else if (store.valid) begin
      stored <= 1'b1;
    end else if (read_clear) begin
      stored <= 1'b0;
    end
  end

  // Overrun: an unread result is overwritten; read clears it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      overrun <= 1'b0;
    end else if (store.valid && stored && !read_clear) begin
      overrun <= 1'b1;
    end else if (read_clear) begin
      overrun <= 1'b0;
    end
  end

  // Packed view for the register file
  assign result = '{value: value, overrun: overrun, stored: stored};

endmodule : adcr_result_slot

`default_nettype wire

// ==== src/adcr_regs.sv ====
// Result, compare and monitor registers of the converter with APB access
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

`include "adcr_params.svh"

module adcr_regs
  import adcr_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // Converter store strobes
  input  wire adcr_store_t SLOT7_STORE,
  input  wire adcr_store_t PRIO_STORE,
  // Interrupts
  output var  logic        MONITOR0_IRQ,
  output var  logic        IRQ
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Byte address to register; misaligned words are unmapped
  function automatic adcr_reg_t decode(input logic [7:0] addr);
    adcr_reg_t r;
    r = ADCR_REG_NONE;
    unique case (addr)
      `ADCR_OFS_SLOT7:   r = ADCR_REG_SLOT7;
      `ADCR_OFS_PRIO:    r = ADCR_REG_PRIO;
      `ADCR_OFS_CMP0:    r = ADCR_REG_CMP0;
      `ADCR_OFS_MONCTL:  r = ADCR_REG_MONCTL;
      `ADCR_OFS_IRQSTAT: r = ADCR_REG_IRQSTAT;
      `ADCR_OFS_IRQMASK: r = ADCR_REG_IRQMASK;
      default:           r = ADCR_REG_NONE;
    endcase
    return r;
  endfunction : decode

  // Result register as a bus word, unused bits zero
  function automatic logic [31:0] result_word(input adcr_result_t res);
    logic [31:0] w;
    w = `ADCR_RST_WORD;
    w[`ADCR_RES_MSB:`ADCR_RES_LSB] = res.value;
    w[`ADCR_OVR_BIT] = res.overrun;
    w[`ADCR_RF_BIT]  = res.stored;
    return w;
  endfunction : result_word

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  adcr_result_t   s7;
  adcr_result_t   sp;
  adcr_reg_t      setup_reg;
  adcr_reg_t      acc_reg;
  adcr_mon_ctrl_t mon_ctrl;
  adcr_store_t    mon_src;
  logic [9:0]     cmp_value;
  logic [9:0]     next_cmp;
  logic [2:0]     irq_status;
  logic [2:0]     irq_mask;
  logic [2:0]     irq_set;
  logic [2:0]     next_status;
  logic [31:0]    next_prdata;
  logic           setup;
  logic           done;
  logic           wr_done;
  logic           rd_done;
  logic           rd_s7;
  logic           rd_sp;
  logic           mon_hit;

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // Setup decodes; access completes one edge later
  assign setup     = PSEL && !PENABLE;
  assign done      = PSEL && PENABLE && PREADY;
  assign wr_done   = done && PWRITE;
  assign rd_done   = done && !PWRITE;
  assign setup_reg = decode(PADDR);
  assign rd_s7     = rd_done && (acc_reg == ADCR_REG_SLOT7);
  assign rd_sp     = rd_done && (acc_reg == ADCR_REG_PRIO);

  // Register latched at setup for the access edge
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc_reg <= ADCR_REG_NONE;
    end else if (setup) begin
      acc_reg <= setup_reg;
    end
  end

  // Zero wait states: ready in the first access cycle
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && (setup_reg == ADCR_REG_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  // Read of the word clears overrun, and stored too unless a store comes in the same cycle
  adcr_result_slot u_slot7 (
    .clk        (CLK),
    .sys_rst    (SYS_RST),
    .store      (SLOT7_STORE),
    .read_clear (rd_s7),
    .result     (s7)
  );

  adcr_result_slot u_prio (
    .clk        (CLK),
    .sys_rst    (SYS_RST),
    .store      (PRIO_STORE),
    .read_clear (rd_sp),
    .result     (sp)
  );

  // ----------------------------------------------------------------
  // Compare and monitor control
  // ----------------------------------------------------------------
  // Byte lanes 1 and 0 carry the compare field
  always_comb begin
    next_cmp = cmp_value;
    if (PSTRB[1]) begin
      next_cmp[9:2] = PWDATA[15:8];
    end
    if (PSTRB[0]) begin
      next_cmp[1:0] = PWDATA[7:6];
    end
  end

  // Locked while enabled so a compare never sees a torn value
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmp_value <= `ADCR_RST_VALUE;
    end else if (wr_done && acc_reg == ADCR_REG_CMP0 && !mon_ctrl.enable) begin
      cmp_value <= next_cmp;
    end
  end

  // Monitor enable, direction and source select
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mon_ctrl <= '{select: ADCR_SEL_SLOT7, direction: ADCR_DIR_SMALLER, enable: 1'b0};
    end else if (wr_done && acc_reg == ADCR_REG_MONCTL && PSTRB[0]) begin
      mon_ctrl.enable    <= PWDATA[`ADCR_MON_EN_BIT];
      mon_ctrl.direction <= adcr_dir_t'(PWDATA[`ADCR_MON_DIR_BIT]);
      mon_ctrl.select    <= adcr_sel_t'(PWDATA[`ADCR_MON_SEL_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Monitor compare
  // ----------------------------------------------------------------
  // Compare the incoming result, the one that is being stored
  assign mon_src = (mon_ctrl.select == ADCR_SEL_PRIO) ? PRIO_STORE : SLOT7_STORE;
  assign mon_hit = mon_ctrl.enable && mon_src.valid &&
                   ((mon_ctrl.direction == ADCR_DIR_LARGER) ?
                    (mon_src.data > cmp_value) : (mon_src.data < cmp_value));

  // One-cycle pulse per hit for the interrupt controller
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MONITOR0_IRQ <= 1'b0;
    end else begin
      MONITOR0_IRQ <= mon_hit;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Events: monitor hit and each overrun; set beats write-one clear
  always_comb begin
    irq_set = `ADCR_RST_IRQ;
    irq_set[`ADCR_IRQ_HIT_BIT]   = mon_hit;
    irq_set[`ADCR_IRQ_SLOT7_OVERRUN_BIT]  = SLOT7_STORE.valid && s7.stored && !rd_s7;
    irq_set[`ADCR_IRQ_PRIORITY_OVERRUN_BIT] = PRIO_STORE.valid && sp.stored && !rd_sp;
    next_status = irq_status;
    if (wr_done && acc_reg == ADCR_REG_IRQSTAT && PSTRB[0]) begin
      next_status = irq_status & ~PWDATA[2:0];
    end
    next_status = next_status | irq_set;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_status <= `ADCR_RST_IRQ;
    end else begin
      irq_status <= next_status;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_mask <= `ADCR_RST_IRQ;
    end else if (wr_done && acc_reg == ADCR_REG_IRQMASK && PSTRB[0]) begin
      irq_mask <= PWDATA[2:0];
    end
  end

  // Level output, one cycle behind the status bits
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Sampled at setup; flags clear only at the access edge
  always_comb begin
    next_prdata = `ADCR_RST_WORD;
    unique case (setup_reg)
      ADCR_REG_SLOT7:   next_prdata = result_word(s7);
      ADCR_REG_PRIO:    next_prdata = result_word(sp);
      ADCR_REG_CMP0:    next_prdata[`ADCR_RES_MSB:`ADCR_RES_LSB] = cmp_value;
      ADCR_REG_MONCTL: begin
        next_prdata[`ADCR_MON_EN_BIT]  = mon_ctrl.enable;
        next_prdata[`ADCR_MON_DIR_BIT] = mon_ctrl.direction;
        next_prdata[`ADCR_MON_SEL_BIT] = mon_ctrl.select;
      end
      ADCR_REG_IRQSTAT: next_prdata[2:0] = irq_status;
      ADCR_REG_IRQMASK: next_prdata[2:0] = irq_mask;
      ADCR_REG_NONE:    next_prdata = `ADCR_RST_WORD;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA <= `ADCR_RST_WORD;
    end else if (setup && !PWRITE) begin
      PRDATA <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_slot7_value_load: assert property (
    SLOT7_STORE.valid |=> s7.value == $past(SLOT7_STORE.data))
    else $error("slot 7 result not loaded");

  a_slot7_overrun_set: assert property (
    SLOT7_STORE.valid && s7.stored && !rd_s7 |=> s7.overrun && irq_status[1])
    else $error("slot 7 overrun not flagged");

  a_slot7_overrun_clear: assert property (
    rd_s7 && !SLOT7_STORE.valid |=> !s7.overrun)
    else $error("slot 7 overrun not cleared by read");

  a_slot7_stored_set: assert property (
    SLOT7_STORE.valid |=> s7.stored)
    else $error("slot 7 stored flag not set");

  a_slot7_stored_clear: assert property (
    rd_s7 && !SLOT7_STORE.valid |=> !s7.stored)
    else $error("slot 7 stored flag not cleared by read");

  a_prio_store_flags: assert property (
    PRIO_STORE.valid && !sp.stored |=> sp.stored && !sp.overrun && sp.value == $past(PRIO_STORE.data))
    else $error("priority result store wrong");

  a_cmp_write_back: assert property (
    setup && PWRITE && setup_reg == ADCR_REG_CMP0 && !mon_ctrl.enable && PSTRB[1:0] == 2'h3
    ##1 wr_done |=> cmp_value == $past(PWDATA[15:6]))
    else $error("compare value not written");

  a_cmp_locked: assert property (
    mon_ctrl.enable |=> $stable(cmp_value))
    else $error("compare value changed while monitor enabled");

  a_mon_hit_pulse: assert property (
    mon_ctrl.enable && SLOT7_STORE.valid && mon_ctrl.select == ADCR_SEL_SLOT7 &&
    mon_ctrl.direction == ADCR_DIR_LARGER && SLOT7_STORE.data > cmp_value
    |=> MONITOR0_IRQ ##1 (IRQ || !$past(irq_mask[0])))
    else $error("monitor hit not signalled");

  a_mon_quiet: assert property (
    !mon_ctrl.enable |=> !MONITOR0_IRQ)
    else $error("monitor interrupt while disabled");

  a_unused_zero: assert property (
    PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000 && PRDATA[5:3] == 3'h0)
    else $error("unused read bits not zero");

  a_prio_overrun_set: assert property (
    PRIO_STORE.valid && sp.stored && !rd_sp |=> sp.overrun && irq_status[2])
    else $error("priority overrun not flagged");

  a_slverr_unmapped: assert property (
    setup && setup_reg == ADCR_REG_NONE |=> PREADY && PSLVERR)
    else $error("unmapped access not refused");

  a_irq_level_high: assert property (
    |(irq_status & irq_mask) |=> IRQ)
    else $error("interrupt low with unmasked status");

  a_irq_level_low: assert property (
    !(|(irq_status & irq_mask)) |=> !IRQ)
    else $error("interrupt high with no unmasked status");

  // Store pulses of the bench are two cycles apart
  c_overrun_seen: cover property (SLOT7_STORE.valid ##2 SLOT7_STORE.valid ##1 s7.overrun);
  c_read_clear: cover property (rd_s7 && s7.stored);
  c_mon_smaller: cover property (mon_hit && mon_ctrl.direction == ADCR_DIR_SMALLER);
  c_prio_hit: cover property (mon_hit && mon_ctrl.select == ADCR_SEL_PRIO);

endmodule : adcr_regs

`default_nettype wire

// ==== sim/adcr_regs_tb.sv ====
// Self-checking testbench of the converter result and monitor registers
`timescale 1ns/100ps
`default_nettype none

`include "adcr_params.svh"

module adcr_regs_tb
  import adcr_pkg::*;
;
  // ------------------------------
  // Signals
  // ------------------------------
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  adcr_store_t slot7_store;
  adcr_store_t prio_store;
  logic        monitor0_irq;
  logic        irq;
  int          errors;
  int          comparisons;
  integer      seed;
  logic [31:0] rd;
  logic        err;
  logic [9:0]  cmp;
  logic [9:0]  d0;
  logic [9:0]  d1;
  logic [7:0]  ra;

  adcr_regs i_dut (
    .CLK          (clk),
    .SYS_RST      (sys_rst),
    .PSEL         (psel),
    .PENABLE      (penable),
    .PWRITE       (pwrite),
    .PADDR        (paddr),
    .PWDATA       (pwdata),
    .PSTRB        (pstrb),
    .PRDATA       (prdata),
    .PREADY       (pready),
    .PSLVERR      (pslverr),
    .SLOT7_STORE  (slot7_store),
    .PRIO_STORE   (prio_store),
    .MONITOR0_IRQ (monitor0_irq),
    .IRQ          (irq)
  );

  // 50 ns period
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ------------------------------
  // Expectations and bus tasks
  // ------------------------------
  function automatic logic [31:0] res_word(logic [9:0] v, logic ovr, logic rf);
    return {16'h0000, v, 4'h0, ovr, rf};
  endfunction : res_word

  // Strict compare, equal values never hit
  function automatic logic mon_hit(logic dir, logic [9:0] d, logic [9:0] c);
    return dir ? (d > c) : (d < c);
  endfunction : mon_hit

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // One transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st);
    int n;
    @(posedge clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0, 4'h0);
    check(name, rd, exp);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 4'hF);
  endtask : wr

  // One-cycle store pulse; monitor pulse looked at in the following cycle
  task automatic store(input logic sel, input logic [9:0] d, input logic exp_irq);
    @(posedge clk);
    if (sel) prio_store <= '{1'h1, d};
    else slot7_store <= '{1'h1, d};
    @(posedge clk);
    slot7_store <= '0;
    prio_store  <= '0;
    #1;
    check("monitor0_irq", {31'h0, monitor0_irq}, {31'h0, exp_irq});
  endtask : store

  task automatic irq_wait(input logic exp);
    repeat (2) @(posedge clk);
    #1;
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask : irq_wait

  // Status read, masked out, masked in, cleared by writing ones
  task automatic irq_chk(input logic [2:0] st);
    rd_chk("irq_status", `ADCR_OFS_IRQSTAT, {29'h0, st});
    wr(`ADCR_OFS_IRQMASK, 32'h0);
    irq_wait(1'h0);
    wr(`ADCR_OFS_IRQMASK, {29'h0, st});
    irq_wait(1'h1);
    wr(`ADCR_OFS_IRQSTAT, {29'h0, st});
    irq_wait(1'h0);
    rd_chk("irq_status", `ADCR_OFS_IRQSTAT, 32'h0);
  endtask : irq_chk

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    end_of_test();
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    seed = 32'h3AB80DCC;
    errors = 0;
    comparisons = 0;
    sys_rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    slot7_store = '0;
    prio_store = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    rd_chk("slot7_rst", `ADCR_OFS_SLOT7, 32'h0);
    rd_chk("prio_rst", `ADCR_OFS_PRIO, 32'h0);
    rd_chk("cmp0_rst", `ADCR_OFS_CMP0, 32'h0);
    // Flags on both result registers, random results
    for (int i = 0; i < 4; i++) begin
      d0 = 10'($random(seed));
      d1 = 10'($random(seed));
      for (int s = 0; s < 2; s++) begin
        ra = s[0] ? `ADCR_OFS_PRIO : `ADCR_OFS_SLOT7;
        store(s[0], d0, 1'h0);
        rd_chk("result_new", ra, res_word(d0, 1'h0, 1'h1));
        rd_chk("result_read", ra, res_word(d0, 1'h0, 1'h0));
        store(s[0], d0, 1'h0);
        store(s[0], d1, 1'h0);
        rd_chk("result_ovr", ra, res_word(d1, 1'h1, 1'h1));
        rd_chk("result_clr", ra, res_word(d1, 1'h0, 1'h0));
      end
    end
    irq_chk(3'h6);
    // Compare value, upper junk must not stick
    cmp = {1'h0, 9'($random(seed))} + 10'h001;
    wr(`ADCR_OFS_CMP0, {16'hFFFF, cmp, 6'h3F});
    rd_chk("cmp0", `ADCR_OFS_CMP0, {16'h0, cmp, 6'h0});
    check("slverr_ok", {31'h0, err}, 32'h0);
    // Every select and direction, values around the compare value
    for (int m = 0; m < 4; m++) begin
      wr(`ADCR_OFS_MONCTL, {29'h0, m[1], m[0], 1'h1});
      wr(`ADCR_OFS_CMP0, {16'h0, ~cmp, 6'h0});
      rd_chk("cmp0_locked", `ADCR_OFS_CMP0, {16'h0, cmp, 6'h0});
      for (int k = 0; k < 3; k++) begin
        d0 = cmp - 10'h001 + 10'(k);
        store(m[1], d0, mon_hit(m[0], d0, cmp));
        store(!m[1], d0, 1'h0);
      end
    end
    irq_chk(3'h7);
    // Disabled monitor stays quiet; byte lane 0 only
    wr(`ADCR_OFS_MONCTL, 32'h2);
    store(1'h0, 10'h3FF, 1'h0);
    apb(1'h1, `ADCR_OFS_CMP0, 32'h0000FFC0, 4'h1);
    rd_chk("cmp0_lane", `ADCR_OFS_CMP0, {16'h0, cmp[9:2], 2'h3, 6'h0});
    // Unmapped and misaligned places
    rd_chk("unmapped", 8'h18, 32'h0);
    check("slverr_rd", {31'h0, err}, 32'h1);
    apb(1'h1, 8'h02, 32'hFFFFFFFF, 4'hF);
    check("slverr_wr", {31'h0, err}, 32'h1);
    // Slot 7 was overwritten unread in the monitor loop, so overrun stays set
    rd_chk("slot7_after", `ADCR_OFS_SLOT7, res_word(10'h3FF, 1'h1, 1'h1));
    end_of_test();
  end

endmodule : adcr_regs_tb

`default_nettype wire
